// *** shared/bpci_pkg.sv ***
// constants for the battery power control interface
// assumes a 50 MHz ref_clk and a free-running 32.768 kHz slow clock pin
package bpci_pkg;
   localparam int unsigned NUM_IN         = 7;
   localparam int unsigned ADDR_W         = 8;

   // register byte offsets, one 32-bit word each
   localparam logic [7:0] OFS_CTRL_STAT   = 8'h00;
   localparam logic [7:0] OFS_LATCH_EN    = 8'h04;
   localparam logic [7:0] OFS_LATCH_CLR   = 8'h08;
   localparam logic [7:0] OFS_INPUT_EN    = 8'h0c;
   localparam logic [7:0] OFS_HOLDOFF     = 8'h10;
   localparam logic [7:0] OFS_POLARITY    = 8'h14;
   localparam logic [7:0] OFS_RISE_FLAGS  = 8'h18;
   localparam logic [7:0] OFS_FALL_FLAGS  = 8'h1c;
   localparam logic [7:0] OFS_BUF_EN      = 8'h20;

   // field positions
   localparam int unsigned BIT_WEEK       = 16;
   localparam int unsigned BIT_RTC        = 17;
   localparam int unsigned BIT_FILT_BYP   = 12;
   localparam int unsigned BIT_FW_SEL     = 11;
   localparam int unsigned BIT_FW_LEVEL   = 10;
   localparam int unsigned BIT_OUT_STAT   = 9;
   localparam int unsigned HOLDOFF_W      = 8;

   // reset values
   localparam logic [6:0] RST_INPUT_EN    = 7'h7f;
   localparam logic [6:0] RST_BUF_EN      = 7'h7f;
   localparam logic [6:0] RST_POLARITY    = 7'h00;
   localparam logic [7:0] RST_HOLDOFF     = 8'h00;

   // timing
   localparam int unsigned SLOW_HZ        = 32768;
   localparam int unsigned TICK_HZ        = 8;
   localparam int unsigned SLOW_PER_TICK  = SLOW_HZ / TICK_HZ;
   localparam int unsigned PRESC_W        = 12;
   localparam int unsigned REF_HZ         = 50000000;
   localparam int unsigned FILT_NS        = 1000;
   localparam int unsigned FILT_CYC       =
      (FILT_NS * (REF_HZ / 1000000) + 999) / 1000;
   localparam int unsigned FILT_W         = 6;
endpackage

// *** hdl/bpci_top.sv ***
// battery-domain power request logic: wake inputs, alarms, inhibit timer
// assumes all pins are asynchronous to ref_clk; register port is the
// embedded controller's own word bus, read data valid one cycle after rd
//
// Functional notes
// - polarity inversion after filter, before status capture
// - edge detection on filtered signal, pre-inversion
// - polarity bits held in battery-domain flops
// - sticky falling and rising flags per input
// - edges recorded regardless of latch; input enable gates them via the buffer
// - edge detection only while buffer enabled
// - buffer on if input enable or buffer enable
// - rail down forces pins to battery function
// - inhibit holds power request deasserted
// - zero holdoff disables inhibit, no counting
// - inhibit asserts within one slow clock
// - 8 Hz tick, 8-bit count, 125 ms steps
// - reset defaults hardware control, filters, active low
// - firmware driving low returns hardware control
// - firmware control ignores inputs, still reports them
// - nine registers at word offsets 00h to 20h
// - hardware output is enabled inputs or alarms
// - rail good and select gives firmware level
// - optional latch of input assertion until cleared
`timescale 1ns/1ps
module bpci_top
(
   input  wire logic                          ref_clk,
   input  wire logic                          rstn,
   input  wire logic [bpci_pkg::NUM_IN-1:0]   wake_input_n,
   input  wire logic                          week_alarm,
   input  wire logic                          rtc_alarm,
   input  wire logic                          standby_rail_good,
   input  wire logic                          power_on_trigger_n,
   input  wire logic                          slow_clk_32k,
   input  wire logic [bpci_pkg::NUM_IN:0]     pin_mux_gpio_sel,
   output logic      [bpci_pkg::NUM_IN:0]     pin_battery_func,
   output logic                               power_request_out,
   output logic                               holdoff_active,
   input  wire logic [bpci_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [31:0]                   reg_wdata,
   output logic      [31:0]                   reg_rdata
);
   localparam int unsigned N = bpci_pkg::NUM_IN;
   localparam int unsigned NS = N + 4; // wake, week, rtc, rail, trigger
   // idle pin levels: wake pins and trigger high, alarms and rail low
   localparam logic [NS-1:0] IDLE_IN = {1'b1, 3'b000, {N{1'b1}}};

   // raw async inputs gathered for one synchroniser bank
   logic [NS-1:0] raw_in;
   logic [NS-1:0] sync1_q;
   logic [NS-1:0] sync2_q;
   logic [NS-1:0] sync3_q;
   logic [NS-1:0] clean_q;
   logic          slow1_q;
   logic          slow2_q;
   logic          slow3_q;
   logic          slow_q;
   logic          slow_rise;

   assign raw_in = {power_on_trigger_n, standby_rail_good, rtc_alarm,
                    week_alarm, wake_input_n};

   // three-stage synchronisers; a level counts once stages two and three agree
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         // idle levels, so no false trigger or wake edge after reset
         sync1_q <= IDLE_IN;
         sync2_q <= IDLE_IN;
         sync3_q <= IDLE_IN;
         slow1_q <= 1'b0;
         slow2_q <= 1'b0;
         slow3_q <= 1'b0;
      end
      else
      begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         slow1_q <= slow_clk_32k;
         slow2_q <= slow1_q;
         slow3_q <= slow2_q;
      end
   end

   // agreed levels; inactive defaults keep wake pins and trigger deasserted
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         clean_q <= IDLE_IN;
         slow_q  <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < NS; i++)
         begin
            if (sync2_q[i] == sync3_q[i])
               clean_q[i] <= sync3_q[i];
         end
         if (slow2_q == slow3_q)
            slow_q <= slow3_q;
      end
   end

   assign slow_rise = (slow2_q == slow3_q) && slow3_q && !slow_q;

   logic rail_good;
   logic week_lvl;
   logic rtc_lvl;
   logic trig_n;
   assign rail_good = clean_q[N+2];
   assign week_lvl  = clean_q[N];
   assign rtc_lvl   = clean_q[N+1];
   assign trig_n    = clean_q[N+3];

   // software-visible state, all battery-domain flops
   logic [N-1:0]                     input_en_q;
   logic [N-1:0]                     buf_en_q;
   logic [N-1:0]                     polarity_q;
   logic [N-1:0]                     latch_en_q;
   logic                             week_le_q;
   logic                             rtc_le_q;
   logic [bpci_pkg::HOLDOFF_W-1:0]   holdoff_q;
   logic                             filt_byp_q;
   logic                             fw_sel_q;
   logic                             fw_level_q;

   logic wr_ctrl;
   logic wr_lclr;
   logic wr_rise;
   logic wr_fall;
   assign wr_ctrl = reg_wr && (reg_addr == bpci_pkg::OFS_CTRL_STAT);
   assign wr_lclr = reg_wr && (reg_addr == bpci_pkg::OFS_LATCH_CLR);
   assign wr_rise = reg_wr && (reg_addr == bpci_pkg::OFS_RISE_FLAGS);
   assign wr_fall = reg_wr && (reg_addr == bpci_pkg::OFS_FALL_FLAGS);

   // plain configuration registers
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         input_en_q <= bpci_pkg::RST_INPUT_EN;
         buf_en_q   <= bpci_pkg::RST_BUF_EN;
         polarity_q <= bpci_pkg::RST_POLARITY;
         latch_en_q <= '0;
         week_le_q  <= 1'b0;
         rtc_le_q   <= 1'b0;
         holdoff_q  <= bpci_pkg::RST_HOLDOFF;
         filt_byp_q <= 1'b0;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            bpci_pkg::OFS_LATCH_EN:
            begin
               latch_en_q <= reg_wdata[N-1:0];
               week_le_q  <= reg_wdata[bpci_pkg::BIT_WEEK];
               rtc_le_q   <= reg_wdata[bpci_pkg::BIT_RTC];
            end
            bpci_pkg::OFS_INPUT_EN:  input_en_q <= reg_wdata[N-1:0];
            bpci_pkg::OFS_HOLDOFF:
               holdoff_q <= reg_wdata[bpci_pkg::HOLDOFF_W-1:0];
            bpci_pkg::OFS_POLARITY:  polarity_q <= reg_wdata[N-1:0];
            bpci_pkg::OFS_BUF_EN:    buf_en_q <= reg_wdata[N-1:0];
            bpci_pkg::OFS_CTRL_STAT:
               filt_byp_q <= reg_wdata[bpci_pkg::BIT_FILT_BYP];
            default: ;
         endcase
      end
   end

   // firmware output control; also cleared while the standby rail is down
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || !rail_good)
      begin
         fw_sel_q   <= 1'b0;
         fw_level_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         fw_level_q <= reg_wdata[bpci_pkg::BIT_FW_LEVEL];
         // driving low under firmware hands control back to hardware
         fw_sel_q   <= reg_wdata[bpci_pkg::BIT_FW_SEL] &&
                       reg_wdata[bpci_pkg::BIT_FW_LEVEL];
      end
   end

   // per-input filter, edge detection, polarity and latch
   logic [N-1:0] filt;
   logic [N-1:0] buf_on;
   logic [N-1:0] asserted;
   logic [N-1:0] prev_q;
   logic [N-1:0] rise_q;
   logic [N-1:0] fall_q;
   logic [N-1:0] latch_q;
   logic [N-1:0] eff_in;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_in
         logic [bpci_pkg::FILT_W-1:0] cnt_q;
         logic                        stab_q;

         // glitch filter: level must hold for the filter time
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
            begin
               cnt_q  <= '0;
               stab_q <= 1'b1;
            end
            else if (clean_q[g] == stab_q)
               cnt_q <= '0;
            else if (cnt_q == bpci_pkg::FILT_W'(bpci_pkg::FILT_CYC - 1))
            begin
               cnt_q  <= '0;
               stab_q <= clean_q[g];
            end
            else
               cnt_q <= cnt_q + 1'b1;
         end

         assign filt[g]     = filt_byp_q ? clean_q[g] : stab_q;
         assign buf_on[g]   = input_en_q[g] | buf_en_q[g];
         // polarity 0 = active low pin
         assign asserted[g] = filt[g] ^ ~polarity_q[g];
         assign eff_in[g]   = asserted[g] | (latch_en_q[g] & latch_q[g]);

         // edge flags use the pre-inversion level; set wins over clear
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
            begin
               prev_q[g] <= 1'b1;
               rise_q[g] <= 1'b0;
               fall_q[g] <= 1'b0;
            end
            else
            begin
               // level always tracked, so a change while off flags nothing
               prev_q[g] <= filt[g];
               if (buf_on[g] && filt[g] && !prev_q[g])
                  rise_q[g] <= 1'b1;
               else if (wr_rise && reg_wdata[g])
                  rise_q[g] <= 1'b0;
               if (buf_on[g] && !filt[g] && prev_q[g])
                  fall_q[g] <= 1'b1;
               else if (wr_fall && reg_wdata[g])
                  fall_q[g] <= 1'b0;
            end
         end

         // assertion latch, held until firmware clears it
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
               latch_q[g] <= 1'b0;
            else if (latch_en_q[g] && asserted[g])
               latch_q[g] <= 1'b1;
            else if (wr_lclr && reg_wdata[g])
               latch_q[g] <= 1'b0;
         end
      end
   endgenerate

   // alarm latches, same set-wins rule
   logic week_lat_q;
   logic rtc_lat_q;
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         week_lat_q <= 1'b0;
         rtc_lat_q  <= 1'b0;
      end
      else
      begin
         if (week_le_q && week_lvl)
            week_lat_q <= 1'b1;
         else if (wr_lclr && reg_wdata[bpci_pkg::BIT_WEEK])
            week_lat_q <= 1'b0;
         if (rtc_le_q && rtc_lvl)
            rtc_lat_q <= 1'b1;
         else if (wr_lclr && reg_wdata[bpci_pkg::BIT_RTC])
            rtc_lat_q <= 1'b0;
      end
   end

   // power-on inhibit timer: prescaler restarts on trigger for exact length
   logic                             trig_prev_q;
   logic                             trig_fall;
   logic [bpci_pkg::PRESC_W-1:0]     presc_q;
   logic [bpci_pkg::HOLDOFF_W-1:0]   tick_cnt_q;
   logic                             inhibit_q;
   logic                             tick;

   assign trig_fall = trig_prev_q && !trig_n;
   assign tick = slow_rise &&
      (presc_q == bpci_pkg::PRESC_W'(bpci_pkg::SLOW_PER_TICK - 1));

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         trig_prev_q <= 1'b1;
         presc_q     <= '0;
         tick_cnt_q  <= '0;
         inhibit_q   <= 1'b0;
      end
      else
      begin
         trig_prev_q <= trig_n;
         if (holdoff_q == '0)
         begin
            inhibit_q  <= 1'b0;
            presc_q    <= '0;
            tick_cnt_q <= '0;
         end
         else if (trig_fall)
         begin
            // set within a few ref cycles, well inside one slow cycle
            inhibit_q  <= 1'b1;
            presc_q    <= '0;
            tick_cnt_q <= '0;
         end
         else if (inhibit_q && slow_rise)
         begin
            presc_q <= tick ? '0 : presc_q + 1'b1;
            if (tick)
            begin
               tick_cnt_q <= tick_cnt_q + 1'b1;
               if (tick_cnt_q + 1'b1 == holdoff_q)
                  inhibit_q <= 1'b0;
            end
         end
      end
   end

   // output selection
   logic hw_req;
   assign hw_req = |(input_en_q & eff_in)
                 | week_lvl | (week_le_q & week_lat_q)
                 | rtc_lvl  | (rtc_le_q & rtc_lat_q);

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         power_request_out <= 1'b0;
      else if (inhibit_q)
         power_request_out <= 1'b0;
      else if (rail_good && fw_sel_q)
         power_request_out <= fw_level_q;
      else
         power_request_out <= hw_req;
   end

   assign holdoff_active = inhibit_q;
   // gpio mux only honoured while the standby rail is good
   assign pin_battery_func = rail_good ? ~pin_mux_gpio_sel : '1;

   // status word: latched or live asserted state, after polarity
   logic [31:0] stat_word;
   always_comb
   begin
      stat_word = '0;
      stat_word[N-1:0] = latch_en_q & latch_q | ~latch_en_q & asserted;
      stat_word[bpci_pkg::BIT_OUT_STAT] = power_request_out;
      stat_word[bpci_pkg::BIT_FW_LEVEL] = fw_level_q;
      stat_word[bpci_pkg::BIT_FW_SEL] = fw_sel_q;
      stat_word[bpci_pkg::BIT_FILT_BYP] = filt_byp_q;
      stat_word[bpci_pkg::BIT_WEEK] = week_lat_q;
      stat_word[bpci_pkg::BIT_RTC] = rtc_lat_q;
   end

   // registered read data; unmapped and write-only offsets read zero
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         reg_rdata <= '0;
         unique case (reg_addr)
            bpci_pkg::OFS_CTRL_STAT:  reg_rdata <= stat_word;
            bpci_pkg::OFS_LATCH_EN:
            begin
               reg_rdata[N-1:0] <= latch_en_q;
               reg_rdata[bpci_pkg::BIT_WEEK] <= week_le_q;
               reg_rdata[bpci_pkg::BIT_RTC] <= rtc_le_q;
            end
            bpci_pkg::OFS_INPUT_EN:   reg_rdata[N-1:0] <= input_en_q;
            bpci_pkg::OFS_HOLDOFF:
               reg_rdata[bpci_pkg::HOLDOFF_W-1:0] <= holdoff_q;
            bpci_pkg::OFS_POLARITY:   reg_rdata[N-1:0] <= polarity_q;
            bpci_pkg::OFS_RISE_FLAGS: reg_rdata[N-1:0] <= rise_q;
            bpci_pkg::OFS_FALL_FLAGS: reg_rdata[N-1:0] <= fall_q;
            bpci_pkg::OFS_BUF_EN:     reg_rdata[N-1:0] <= buf_en_q;
            default: ;
         endcase
      end
   end
endmodule

// *** dv/bpci_assertions.sv ***
// port checker for the battery power control block
// bound to bpci_top; one ref_clk domain, rstn synchronous active low
`timescale 1ns/1ps
module bpci_checker
(
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic        power_on_trigger_n,
   input wire logic        standby_rail_good,
   input wire logic [7:0]  pin_battery_func,
   input wire logic        power_request_out,
   input wire logic        holdoff_active,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata
);
   logic [7:0] hold_q; // shadow of the holdoff count

   // shadow tells the trigger check whether the timer is armed
   always_ff @(posedge ref_clk)
      if (!rstn)
         hold_q <= 8'h00;
      else if (reg_wr && reg_addr == 8'h10)
         hold_q <= reg_wdata[7:0];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_reset_out;
      disable iff (1'b0) !rstn |=> !power_request_out && !holdoff_active;
   endproperty
   a_reset_out: assert property (p_reset_out)
      else $error("outputs not cleared by reset");

   property p_reset_rdata;
      disable iff (1'b0) !rstn |=> reg_rdata == 32'h0;
   endproperty
   a_reset_rdata: assert property (p_reset_rdata)
      else $error("read data not cleared by reset");

   property p_inhibit;
      holdoff_active && $past(holdoff_active) |-> !power_request_out;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("power request while inhibited");

   property p_rail_pins;
      !standby_rail_good [*5] |-> pin_battery_func == 8'hff;
   endproperty
   a_rail_pins: assert property (p_rail_pins)
      else $error("pins not in battery function with rail down");

   property p_unmapped;
      reg_rd && (reg_addr == 8'h08 || reg_addr > 8'h20 ||
         reg_addr[1:0] != 2'b00) |=> reg_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");

   // timer sees the new count one edge after the write lands
   property p_zero_hold;
      reg_wr && reg_addr == 8'h10 && reg_wdata[7:0] == 8'h00
         |=> ##1 !holdoff_active [*3];
   endproperty
   a_zero_hold: assert property (p_zero_hold)
      else $error("inhibit with zero holdoff");

   property p_trigger;
      $fell(power_on_trigger_n) && hold_q != 8'h00 |-> ##[1:10] holdoff_active;
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("inhibit late after trigger");

   property p_fw_high;
      (standby_rail_good && !holdoff_active) [*8] ##0 (reg_wr &&
         reg_addr == 8'h00 && reg_wdata[11:10] == 2'b11)
         |-> ##[1:4] power_request_out;
   endproperty
   a_fw_high: assert property (p_fw_high)
      else $error("firmware level not driven");
endmodule

bind bpci_top bpci_checker u_chk (.ref_clk, .rstn, .power_on_trigger_n,
   .standby_rail_good, .pin_battery_func, .power_request_out,
   .holdoff_active, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

// *** dv/bpci_partner.sv ***
// far side model: buttons, slow clock and the standby rail regulator
// assumes active-low buttons on pins with pull-ups
`timescale 1ns/1ps
module bpci_partner
(
   input wire logic       ref_clk,
   input wire logic [6:0] press,
   input wire logic       rail_keep,
   input wire logic       power_request_out,
   output logic     [6:0] wake_input_n,
   output logic           slow_clk_32k,
   output logic           standby_rail_good
);
   logic [3:0] req_q = 4'h0; // regulator ramp delay

   // released buttons float up to the pull-up level
   assign wake_input_n = ~press;

   // free-running slow clock, sped up so a holdoff tick fits the run
   initial slow_clk_32k = 1'b0;
   always #80 slow_clk_32k = ~slow_clk_32k;

   // regulator brings the rail up a few cycles after the request
   always @(posedge ref_clk) req_q <= {req_q[2:0], power_request_out};
   assign standby_rail_good = rail_keep | req_q[3];
endmodule

// *** dv/test_battery_power_control_interface.sv ***
// testbench for the battery power control block
// drives the word register port and the partner's buttons and rail
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module test_battery_power_control_interface;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [6:0]  press = 7'h00;
   logic        rail_keep = 1'b1;
   logic        week_alarm = 1'b0;
   logic        rtc_alarm = 1'b0;
   logic        power_on_trigger_n = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic [6:0]  wake_input_n;
   logic        slow_clk_32k;
   logic        standby_rail_good;
   logic [7:0]  pin_battery_func;
   logic        power_request_out;
   logic        holdoff_active;
   logic [31:0] reg_rdata;
   int          errors = 0;
   int          checked = 0;
   logic [7:0]  ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                              8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
   logic [31:0] dflt [10] = '{32'h0, 32'h0, 32'h0, 32'h7f, 32'h0,
                              32'h0, 32'h0, 32'h0, 32'h7f, 32'h0};

   bpci_top uut (.ref_clk(ref_clk), .rstn(rstn),
      .wake_input_n(wake_input_n), .week_alarm(week_alarm),
      .rtc_alarm(rtc_alarm), .standby_rail_good(standby_rail_good),
      .power_on_trigger_n(power_on_trigger_n), .slow_clk_32k(slow_clk_32k),
      .pin_mux_gpio_sel(8'hff), .pin_battery_func(pin_battery_func),
      .power_request_out(power_request_out),
      .holdoff_active(holdoff_active), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   bpci_partner far (.ref_clk(ref_clk), .press(press),
      .rail_keep(rail_keep), .power_request_out(power_request_out),
      .wake_input_n(wake_input_n), .slow_clk_32k(slow_clk_32k),
      .standby_rail_good(standby_rail_good));

   // 50 MHz reference clock
   always #10 ref_clk = ~ref_clk;

   // all tasks start and end 1 ns after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      // let an edge pass with the strobe low before the next write
      cyc(1);
   endtask
   task automatic chk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      cyc(1);
      `CHK(n, e, reg_rdata)
   endtask
   task automatic clr;
      wr(8'h18, 32'h7f);
      wr(8'h1c, 32'h7f);
   endtask
   task automatic trig;
      power_on_trigger_n = 1'b0;
      cyc(20);
      power_on_trigger_n = 1'b1;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watchdog: tests need about 36k cycles
   initial
   begin
      #(60000 * 20);
      errors++;
      final_report();
   end

   initial
   begin
      cyc(8);
      rstn = 1'b1;
      // defaults, including the unmapped and write-only offsets
      cyc(80);
      for (int i = 0; i < 10; i++)
         chk("reset", ofs[i], dflt[i]);
      `CHK("mux", 8'h00, pin_battery_func)
      $display("test reset done");
      // press and release, flags cleared one at a time
      press = 7'h01;
      cyc(80);
      `CHK("out", 1'b1, power_request_out)
      chk("status", 8'h00, 32'h201);
      chk("fall", 8'h1c, 32'h1);
      press = 7'h00;
      cyc(80);
      `CHK("out", 1'b0, power_request_out)
      chk("rise", 8'h18, 32'h1);
      wr(8'h18, 32'h1);
      chk("rise clr", 8'h18, 32'h0);
      chk("fall kept", 8'h1c, 32'h1);
      wr(8'h1c, 32'h1);
      // active-high pin: edges still seen before inversion
      wr(8'h14, 32'h2);
      cyc(80);
      chk("invert", 8'h00, 32'h202);
      chk("no edge", 8'h1c, 32'h0);
      press = 7'h02;
      cyc(80);
      chk("raw edge", 8'h1c, 32'h2);
      `CHK("out", 1'b0, power_request_out)
      wr(8'h14, 32'h0);
      press = 7'h00;
      cyc(80);
      clr();
      $display("test pins done");
      // input off but buffer on, then both off, then input alone
      wr(8'h0c, 32'h7b);
      press = 7'h04;
      cyc(80);
      `CHK("out", 1'b0, power_request_out)
      chk("status", 8'h00, 32'h4);
      chk("edge", 8'h1c, 32'h4);
      press = 7'h00;
      wr(8'h20, 32'h7b);
      cyc(80);
      clr();
      press = 7'h04;
      cyc(80);
      chk("buf off", 8'h1c, 32'h0);
      press = 7'h00;
      cyc(80);
      wr(8'h0c, 32'h7f);
      cyc(80);
      chk("no stale", 8'h18, 32'h0);
      clr();
      press = 7'h04;
      cyc(80);
      chk("buf by en", 8'h1c, 32'h4);
      press = 7'h00;
      wr(8'h20, 32'h7f);
      cyc(80);
      clr();
      // latched pin holds the request until cleared
      wr(8'h04, 32'h8);
      press = 7'h08;
      cyc(80);
      press = 7'h00;
      cyc(80);
      `CHK("latched", 1'b1, power_request_out)
      wr(8'h08, 32'h8);
      cyc(4);
      `CHK("unlatched", 1'b0, power_request_out)
      wr(8'h04, 32'h0);
      clr();
      for (int i = 0; i < 2; i++)
      begin
         {rtc_alarm, week_alarm} = 2'b01 << i;
         cyc(80);
         `CHK("alarm", 1'b1, power_request_out)
         {rtc_alarm, week_alarm} = 2'b00;
         cyc(80);
         `CHK("alarm", 1'b0, power_request_out)
      end
      $display("test enables done");
      // firmware takes the output, then drops it and hands it back
      wr(8'h00, 32'hc00);
      cyc(8);
      `CHK("fw", 1'b1, power_request_out)
      press = 7'h01;
      cyc(80);
      chk("fw status", 8'h00, 32'he01);
      press = 7'h00;
      cyc(80);
      wr(8'h00, 32'h800);
      cyc(8);
      `CHK("fw low", 1'b0, power_request_out)
      chk("hw back", 8'h00, 32'h0);
      rail_keep = 1'b0;
      cyc(10);
      `CHK("mux", 8'hff, pin_battery_func)
      press = 7'h01;
      cyc(80);
      `CHK("rail off", 1'b1, power_request_out)
      rail_keep = 1'b1;
      press = 7'h00;
      cyc(80);
      clr();
      $display("test firmware done");
      // inhibit: zero count disables, one count holds 4096 slow edges
      wr(8'h10, 32'h1);
      trig();
      `CHK("inhibit", 1'b1, holdoff_active)
      wr(8'h10, 32'h0);
      cyc(2);
      `CHK("zero", 1'b0, holdoff_active)
      trig();
      `CHK("zero", 1'b0, holdoff_active)
      wr(8'h10, 32'h1);
      trig();
      week_alarm = 1'b1;
      cyc(30000);
      `CHK("holding", 1'b1, holdoff_active)
      `CHK("held", 1'b0, power_request_out)
      cyc(3500);
      `CHK("released", 1'b0, holdoff_active)
      `CHK("resumed", 1'b1, power_request_out)
      week_alarm = 1'b0;
      $display("test inhibit done");
      final_report();
   end
endmodule
